// >>> rtl/udc_counter.sv
/*
 * udc_counter: 4-bit synchronous up/down counter with preset, master and
 * synchronous clear, two count enables, terminal count and clocked carry,
 * plus a classic wishbone slave for status and an output-disable control.
 * Assumes: control pins come from logic on I_CLK; the tri-state wire is
 * resolved outside from O_COUNT_OUT and O_COUNT_OE.
 */
// Our own choices: the Wishbone register port and the register offsets.
// What this block does
// - counts modulo 16; up wraps 15 to 0, down wraps 0 to 15.
// - all count changes except master clear happen on the rising clock edge; clocked carry falls on the falling edge.
// - priority: master clear, sync clear, load, count, then hold.
// - master clear low forces the count to zero at once, overriding all.
// - sync clear low zeroes the count on the next rising edge.
// - load enable low loads preset data on the next rising edge.
// - counts only when both count enables are low, otherwise holds.
// - direction input selects increment or decrement.
// - terminal count low combinationally when trickle low and at end value.
// - clocked carry low during clock low after enables and terminal count low.
// - output enable low with the control float bit clear drives count outputs with the counter state.
// - output enable high floats the outputs; counting continues.
module udc_counter
   import udc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_MASTER_CLEAR_N,
   input wire logic I_SYNC_CLEAR_N,
   input wire logic I_LOAD_ENABLE_N,
   input wire logic I_COUNT_ENABLE_PARALLEL_N,
   input wire logic I_COUNT_ENABLE_TRICKLE_N,
   input wire logic I_UP_DOWN,
   input wire logic I_OUTPUT_ENABLE_N,
   input wire logic [3:0] I_PRESET_DATA,
   output logic [3:0] O_COUNT_OUT,
   output logic O_COUNT_OE,
   output logic O_TERMINAL_COUNT_N,
   output logic O_CLOCKED_CARRY_N,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [7:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK
);

   udc_state_t st_r;
   udc_state_t st_nxt;
   udc_mode_t mode;
   logic tc_n;
   logic cc_arm_r;
   logic oe;

   // mode selection by fixed precedence below the asynchronous clear
   function automatic udc_mode_t pick_mode(input logic sclr_n, input logic load_n,
                                           input logic cep_n, input logic cet_n);
      udc_mode_t m;
      m = UDC_MODE_HOLD;
      if (!sclr_n) begin
         m = UDC_MODE_SCLR;
      end else if (!load_n) begin
         m = UDC_MODE_LOAD;
      end else if (!cep_n && !cet_n) begin
         m = UDC_MODE_COUNT;
      end
      return m;
   endfunction

   // terminal count decode on state, direction and trickle enable
   always_comb begin
      tc_n = 1'b1;
      if (!I_COUNT_ENABLE_TRICKLE_N) begin
         if (I_UP_DOWN && st_r.cnt == UDC_CNT_MAX) begin
            tc_n = 1'b0;
         end else if (!I_UP_DOWN && st_r.cnt == UDC_CNT_MIN) begin
            tc_n = 1'b0;
         end
      end
   end

   assign mode = pick_mode(I_SYNC_CLEAR_N, I_LOAD_ENABLE_N,
                           I_COUNT_ENABLE_PARALLEL_N, I_COUNT_ENABLE_TRICKLE_N);

   // next state: counter and wishbone slave
   always_comb begin
      st_nxt = st_r;
      case (mode)
         UDC_MODE_SCLR: begin
            st_nxt.cnt = UDC_CNT_RST;
         end
         UDC_MODE_LOAD: begin
            st_nxt.cnt = I_PRESET_DATA;
         end
         UDC_MODE_COUNT: begin
            // 4-bit arithmetic wraps naturally modulo 16
            if (I_UP_DOWN) begin
               st_nxt.cnt = st_r.cnt + 4'h1;
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         UDC_MODE_HOLD: begin
            st_nxt.cnt = st_r.cnt;
         end
         default: begin
            st_nxt.cnt = st_r.cnt;
         end
      endcase
      // single-wait-state slave: ack one cycle after the request, then drop
      st_nxt.ack = I_WB_CYC && I_WB_STB && !st_r.ack;
      st_nxt.rdata = 32'h0000_0000;
      if (I_WB_CYC && I_WB_STB && !st_r.ack) begin
         if (I_WB_WE) begin
            if (I_WB_ADR == UDC_ADR_CTRL && I_WB_SEL[0]) begin
               st_nxt.ctrl_hiz = I_WB_DAT[UDC_CTRL_HIZ_BIT];
            end
         end else if (I_WB_ADR == UDC_ADR_STATUS) begin
            st_nxt.rdata[UDC_ST_CNT_LSB +: 4] = st_r.cnt;
            st_nxt.rdata[UDC_ST_TC_BIT] = tc_n;
            st_nxt.rdata[UDC_ST_CC_BIT] = O_CLOCKED_CARRY_N;
            st_nxt.rdata[UDC_ST_UP_BIT] = I_UP_DOWN;
            st_nxt.rdata[UDC_ST_OE_BIT] = oe;
         end else if (I_WB_ADR == UDC_ADR_CTRL) begin
            st_nxt.rdata[UDC_CTRL_HIZ_BIT] = st_r.ctrl_hiz;
         end
      end
   end

   // state register; master clear acts without the clock
   always_ff @(posedge I_CLK or negedge I_RST_N or negedge I_MASTER_CLEAR_N) begin
      if (!I_RST_N) begin
         st_r <= '0;
      end else if (!I_MASTER_CLEAR_N) begin
         st_r.cnt <= UDC_CNT_RST;
         st_r.ack <= 1'b0;
         st_r.rdata <= 32'h0000_0000;
         st_r.ctrl_hiz <= UDC_CTRL_HIZ_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // carry condition caught on the falling edge
   always_ff @(negedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cc_arm_r <= 1'b0;
      end else begin
         cc_arm_r <= !I_COUNT_ENABLE_PARALLEL_N && !I_COUNT_ENABLE_TRICKLE_N && !tc_n;
      end
   end

   // carry is low only while the clock is low after an armed falling edge
   assign O_CLOCKED_CARRY_N = !(cc_arm_r && !I_CLK);
   assign O_TERMINAL_COUNT_N = tc_n;

   // output drive, independent of counting
   assign oe = !I_OUTPUT_ENABLE_N && !st_r.ctrl_hiz;
   assign O_COUNT_OE = oe;
   assign O_COUNT_OUT = st_r.cnt;
   assign O_WB_DAT = st_r.rdata;
   assign O_WB_ACK = st_r.ack;

endmodule

// >>> rtl/udc_pkg.sv
/*
 * udc_pkg: constants and types shared by the 4-bit up/down counter.
 * Assumes: a single 250 MHz clock domain.
 */
package udc_pkg;

   // counter range
   localparam logic [3:0] UDC_CNT_MAX = 4'hf;
   localparam logic [3:0] UDC_CNT_MIN = 4'h0;
   localparam logic [3:0] UDC_CNT_RST = 4'h0;

   // wishbone register map, byte addresses
   localparam logic [7:0] UDC_ADR_STATUS = 8'h00;
   localparam logic [7:0] UDC_ADR_CTRL = 8'h04;

   // status register field positions
   localparam int UDC_ST_CNT_LSB = 0;
   localparam int UDC_ST_TC_BIT = 4;
   localparam int UDC_ST_CC_BIT = 5;
   localparam int UDC_ST_UP_BIT = 6;
   localparam int UDC_ST_OE_BIT = 7;

   // control register field and reset value
   localparam int UDC_CTRL_HIZ_BIT = 0;
   localparam logic UDC_CTRL_HIZ_RST = 1'b0;

   // operating modes below the asynchronous clear, one-hot
   typedef enum logic [3:0] {
      UDC_MODE_SCLR = 4'h1,
      UDC_MODE_LOAD = 4'h2,
      UDC_MODE_COUNT = 4'h4,
      UDC_MODE_HOLD = 4'h8
   } udc_mode_t;

   // rising-edge register state of the counter; the falling-edge carry arm is kept apart
   typedef struct packed {
      logic [3:0] cnt;
      logic ctrl_hiz;
      logic ack;
      logic [31:0] rdata;
   } udc_state_t;

endpackage

// >>> test/test_udc_counter.sv
/* bench for udc_counter; assumes package, checker and stage model compiled */
module test_udc_counter
   import udc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, mc_n = 1, sc_n = 1, ld_n = 1, cep_n = 1, cet_n = 1;
   logic ud = 1, oe_n = 0, cyc = 0, stb = 0, we = 0, oe, tc_n, cc_n, ack;
   logic [3:0] pd = 0, m = 0, cnt, e, q[$];
   logic [7:0] adr = 0;
   logic [31:0] wd = 0, rd, rdat;
   int error_cnt = 0, n_checks = 0, seed = 34144;
   always #2 clk = !clk;
   udc_counter u_udc_counter (.I_CLK(clk), .I_RST_N(rst_n), .I_MASTER_CLEAR_N(mc_n),
      .I_SYNC_CLEAR_N(sc_n), .I_LOAD_ENABLE_N(ld_n), .I_COUNT_ENABLE_PARALLEL_N(cep_n),
      .I_COUNT_ENABLE_TRICKLE_N(cet_n), .I_UP_DOWN(ud), .I_OUTPUT_ENABLE_N(oe_n),
      .I_PRESET_DATA(pd), .O_COUNT_OUT(cnt), .O_COUNT_OE(oe), .O_TERMINAL_COUNT_N(tc_n),
      .O_CLOCKED_CARRY_N(cc_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
      .I_WB_SEL(4'hf), .I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack));
   udc_stage_model u_udc_stage_model (.i_clk(clk), .i_rst_n(rst_n), .i_carry_n(tc_n), .o_hi());
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // random mode bits; the expected count is noted for the monitor
   task step(input logic [7:0] r);
      sc_n <= r[0] | r[1]; ld_n <= r[2] | r[3]; cep_n <= r[4] & r[5]; cet_n <= r[5] & r[6];
      ud <= r[7]; pd <= r[7:4]; oe_n <= r[3] & r[6];
      if (!(r[0] | r[1])) m = 4'h0;
      else if (!(r[2] | r[3])) m = r[7:4];
      else if (!(r[4] & r[5]) && !(r[5] & r[6])) m = r[7] ? m + 4'h1 : m - 4'h1;
      @(posedge clk);
      q.push_back(m);
   endtask
   // classic single wishbone cycle, waits for ack under a bound
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
      do @(posedge clk); while (ack !== 1'b1 && ++i < 20);
      rd = rdat;
      if (i == 20) error_cnt++; // timeout counts and the run goes on to the report
      cyc <= 0; stb <= 0;
      @(posedge clk);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // monitor: oldest noted count against the output
   always @(negedge clk) if (q.size() > 0) begin
      e = q.pop_front();
      chk("count", {28'h0, cnt}, {28'h0, e});
      chk("tc", {31'h0, tc_n}, {31'h0, !(!cet_n && e == (ud ? UDC_CNT_MAX : UDC_CNT_MIN))});
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      repeat (400) step(8'($random(seed)));
      step(8'h3f);
      $display("random mode test done");
      wb(1, UDC_ADR_CTRL, 32'h1);
      chk("oe", {31'h0, oe}, 32'h0);
      wb(0, UDC_ADR_CTRL, 32'h0);
      chk("ctrl", rd, 32'h1);
      wb(0, 8'h08, 32'h0);
      chk("unmapped", rd, 32'h0);
      wb(0, UDC_ADR_STATUS, 32'h0);
      chk("status", {28'h0, rd[3:0]}, {28'h0, m});
      // clocked carry: load 15, count up, carry low while the clock is low
      sc_n <= 1; ld_n <= 0; pd <= 4'hf; cep_n <= 0; cet_n <= 0; ud <= 1;
      @(posedge clk);
      ld_n <= 1;
      @(negedge clk);
      #1 chk("cc low", {31'h0, cc_n}, 32'h0);
      chk("tc at max", {31'h0, tc_n}, 32'h0);
      @(posedge clk);
      cep_n <= 1;
      #1 chk("cc high", {31'h0, cc_n}, 32'h1);
      chk("wrap", {28'h0, cnt}, 32'h0);
      mc_n <= 0;
      #1 chk("mclr", {28'h0, cnt}, 32'h0);
      @(posedge clk);
      mc_n <= 1;
      @(posedge clk);
      $display("register and clear test done");
      print_verdict();
   end
endmodule
bind udc_counter udc_counter_chk u_udc_counter_chk (.*);

// >>> test/udc_counter_sva.sv
/* port checker for udc_counter; assumes it is bound to the top module */
module udc_counter_chk
   import udc_pkg::*;
(
   input logic I_CLK,
   input logic I_RST_N,
   input logic I_MASTER_CLEAR_N,
   input logic I_SYNC_CLEAR_N,
   input logic I_LOAD_ENABLE_N,
   input logic I_COUNT_ENABLE_PARALLEL_N,
   input logic I_COUNT_ENABLE_TRICKLE_N,
   input logic I_UP_DOWN,
   input logic I_OUTPUT_ENABLE_N,
   input logic [3:0] I_PRESET_DATA,
   input logic [3:0] O_COUNT_OUT,
   input logic O_COUNT_OE,
   input logic O_TERMINAL_COUNT_N,
   input logic O_CLOCKED_CARRY_N
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run;
   logic arm_r;
   // both count enables active, and the carry condition at the falling edge
   assign run = !I_COUNT_ENABLE_PARALLEL_N && !I_COUNT_ENABLE_TRICKLE_N;
   always_ff @(negedge I_CLK) arm_r <= run && !O_TERMINAL_COUNT_N;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N || !I_MASTER_CLEAR_N);
   sequence count_s;
      I_SYNC_CLEAR_N && I_LOAD_ENABLE_N && run;
   endsequence
   sclr_zero_a: assert property (!I_SYNC_CLEAR_N |=> O_COUNT_OUT == UDC_CNT_RST)
      else $error("sync clear missed");
   load_preset_a:
   assert property (I_SYNC_CLEAR_N && !I_LOAD_ENABLE_N |=> O_COUNT_OUT == $past(I_PRESET_DATA))
      else $error("preset not loaded");
   count_up_a:
   assert property (count_s ##0 I_UP_DOWN |=> O_COUNT_OUT == $past(O_COUNT_OUT) + 4'h1)
      else $error("up step wrong");
   count_down_a:
   assert property (count_s ##0 !I_UP_DOWN |=> O_COUNT_OUT == $past(O_COUNT_OUT) - 4'h1)
      else $error("down step wrong");
   hold_state_a:
   assert property (I_SYNC_CLEAR_N && I_LOAD_ENABLE_N && !run |=> $stable(O_COUNT_OUT))
      else $error("hold changed count");
   term_count_a:
   assert property (O_TERMINAL_COUNT_N == !(!I_COUNT_ENABLE_TRICKLE_N
      && O_COUNT_OUT == (I_UP_DOWN ? UDC_CNT_MAX : UDC_CNT_MIN))) else $error("tc wrong");
   carry_pulse_a: assert property (O_CLOCKED_CARRY_N == !arm_r)
      else $error("clocked carry wrong");
   float_out_a: assert property (I_OUTPUT_ENABLE_N |-> !O_COUNT_OE)
      else $error("outputs driven while disabled");
endmodule

// >>> test/udc_stage_model.sv
/* next cascaded stage; assumes the lower stage terminal count as enable */
module udc_stage_model (
   input logic i_clk,
   input logic i_rst_n,
   input logic i_carry_n,
   output logic [3:0] o_hi
);
   timeunit 1ns;
   timeprecision 1ps;
   // advances synchronously, never clocked by the glitchy terminal count
   always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n) o_hi <= 4'h0;
      else if (!i_carry_n) o_hi <= o_hi + 4'h1;
endmodule
